/* File: rtl/xtcc_pkg.sv */
// constants and types for the crosstalk calibration control block
package xtcc_pkg;
    // register offsets
    localparam logic [7:0] OFS_COEF_PAIR_A = 8'h2d;
    localparam logic [7:0] OFS_LEAK_CTRL   = 8'h2e;
    localparam logic [7:0] OFS_INPH_CH0_LO = 8'h2f;
    localparam logic [7:0] OFS_QUAD_CH0_LO = 8'h30;
    // reset values
    localparam logic [23:0] RST_COEF_PAIR_A = 24'h000000;
    localparam logic [23:0] RST_LEAK_CTRL   = 24'h8001a0;
    localparam logic [23:0] RST_INPH_CH0_LO = 24'h000000;
    localparam logic [23:0] RST_QUAD_CH0_LO = 24'h000000;
    // writable bit masks of reserved-bearing registers
    localparam logic [23:0] MASK_LEAK_CTRL  = 24'hffdfff;
    localparam logic [23:0] MASK_QUAD_CH0   = 24'hf0ffff;
    // readback select codes
    localparam logic [2:0] SEL_ELECTRICAL  = 3'h0;
    localparam logic [2:0] SEL_OPTICAL     = 3'h1;
    localparam logic [2:0] SEL_RAW         = 3'h2;
    localparam logic [2:0] SEL_FRAME_COUNT = 3'h3;
    // forced scale base exponent
    localparam logic [3:0] FORCED_SCALE_BASE = 4'h6;
    // filter fraction width
    localparam int FILT_FRAC = 16;
    // control register layout, msb first
    typedef struct packed {
        logic [3:0] leak_filter_tau_exp;
        logic [2:0] optical_leak_scale_exp;
        logic [2:0] electrical_leak_scale_exp;
        logic       reserved_zero;
        logic       optical_leak_cal_trigger;
        logic [2:0] readback_source_select;
        logic       optical_leak_use_programmed;
        logic       optical_leak_use_filter;
        logic       electrical_leak_use_programmed;
        logic       electrical_leak_use_filter;
        logic       electrical_leak_cal_trigger;
        logic       auto_gain_scale_off;
        logic [2:0] manual_gain_scale;
    } xtcc_ctrl_s;
    // in-phase and quadrature pair
    typedef struct packed {
        logic signed [23:0] i;
        logic signed [23:0] q;
    } xtcc_iq_s;
endpackage : xtcc_pkg

/* File: rtl/xtcc_top.sv */
// crosstalk calibration control registers and compensation datapath
`timescale 1ns/1ps
module xtcc_top (
    // clock, reset, enable
    input  wire logic                MCLK,
    input  wire logic                SRST,
    input  wire logic                CE,
    // register port
    input  wire logic                REG_WR_EN,
    input  wire logic                REG_RD_EN,
    input  wire logic [7:0]          REG_ADDR,
    input  wire logic [23:0]         REG_WDATA,
    output logic      [23:0]         REG_RDATA,
    output logic                     REG_HIT,
    // measurement input
    input  wire logic                FRAME_DONE,
    input  wire logic signed [15:0]  RAW_I,
    input  wire logic signed [15:0]  RAW_Q,
    input  wire logic [1:0]          EMITTER_CHANNEL,
    input  wire logic [3:0]          AUTO_SCALE_EXP,
    // current selection
    input  wire logic                ADAPTIVE_RANGE_SWITCH_ON,
    input  wire logic                AMPLITUDE_WANTS_HIGH,
    input  wire logic                MANUAL_HIGH_CURRENT,
    // outputs to phase engine
    output logic                     EMITTER_HIGH_CURRENT,
    output logic [11:0]              THERMAL_PHASE_COEF,
    output xtcc_pkg::xtcc_iq_s       CORRECTED_IQ,
    output logic signed [3:0]        DIGITAL_SCALE_EXP,
    output logic [23:0]              LEAK_INPHASE_READBACK,
    output logic [23:0]              LEAK_QUAD_READBACK
);
    import xtcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // sign extend a programmed value and shift by its exponent
    function automatic logic signed [23:0] scale_up(input logic [15:0] v,
                                                    input logic [2:0] e);
        logic signed [23:0] ext;
        ext = {{8{v[15]}}, v};
        return ext <<< e;
    endfunction

    // one step of a first order filter with tau of two to the exponent
    function automatic logic signed [39:0] filt_step(input logic signed [39:0] acc,
                                                     input logic signed [23:0] s,
                                                     input logic [3:0] tau,
                                                     input logic use_filt);
        logic signed [39:0] target;
        logic signed [39:0] diff;
        target = {s, 16'h0000};
        diff   = target - acc;
        return use_filt ? acc + (diff >>> tau) : target;
    endfunction

    // readback source routing; invalid codes read zero
    function automatic logic [23:0] route_readback(input logic [2:0]  sel,
                                                   input logic [23:0] elec,
                                                   input logic [23:0] opt,
                                                   input logic [23:0] raw,
                                                   input logic [15:0] count);
        case (sel)
            SEL_ELECTRICAL:  return elec;
            SEL_OPTICAL:     return opt;
            SEL_RAW:         return raw;
            SEL_FRAME_COUNT: return {8'h00, count};
            default:         return 24'h000000;                    // codes four to seven
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register file

    logic [23:0] coef_pair_a;
    logic [23:0] leak_ctrl;
    logic [23:0] inph_ch0_lo;
    logic [23:0] quad_ch0_lo;
    xtcc_ctrl_s  ctrl;

    wire hit_coef = (REG_ADDR == OFS_COEF_PAIR_A);
    wire hit_ctrl = (REG_ADDR == OFS_LEAK_CTRL);
    wire hit_inph = (REG_ADDR == OFS_INPH_CH0_LO);
    wire hit_quad = (REG_ADDR == OFS_QUAD_CH0_LO);
    wire any_hit  = hit_coef | hit_ctrl | hit_inph | hit_quad;

    assign ctrl = xtcc_ctrl_s'(leak_ctrl);

    // taken accesses; a low enable freezes reset as well
    wire wr_coef = CE && REG_WR_EN && hit_coef;
    wire wr_ctrl = CE && REG_WR_EN && hit_ctrl;
    wire wr_inph = CE && REG_WR_EN && hit_inph;
    wire wr_quad = CE && REG_WR_EN && hit_quad;
    wire rd_take = CE && REG_RD_EN;

    // writes; reserved bits never store a one
    always_ff @(posedge MCLK) begin
        if (CE && SRST) begin
            coef_pair_a <= RST_COEF_PAIR_A;
            leak_ctrl   <= RST_LEAK_CTRL;
            inph_ch0_lo <= RST_INPH_CH0_LO;
            quad_ch0_lo <= RST_QUAD_CH0_LO;
        end else begin
            if (wr_coef) coef_pair_a <= REG_WDATA;
            if (wr_ctrl) leak_ctrl <= REG_WDATA & MASK_LEAK_CTRL;
            if (wr_inph) inph_ch0_lo <= REG_WDATA;
            if (wr_quad) quad_ch0_lo <= REG_WDATA & MASK_QUAD_CH0;
        end
    end

    // read data mux, unmapped reads return zero
    logic [23:0] rd_mux;
    assign rd_mux = hit_coef ? coef_pair_a :
                    hit_ctrl ? leak_ctrl :
                    hit_inph ? inph_ch0_lo :
                    hit_quad ? quad_ch0_lo : 24'h000000;

    // registered read answer
    always_ff @(posedge MCLK) begin
        if (CE && SRST) begin
            REG_RDATA <= 24'h000000;
            REG_HIT   <= 1'b0;
        end else if (rd_take) begin
            REG_RDATA <= rd_mux;
            REG_HIT   <= any_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // coefficient and current selection

    logic [11:0] coef_ch1_low;
    logic [11:0] coef_ch0_high;
    logic [11:0] coef_ch1_high;
    logic        high_sel;

    assign coef_ch1_low  = coef_pair_a[23:12];
    assign coef_ch0_high = coef_pair_a[11:0];
    assign coef_ch1_high = {inph_ch0_lo[23:16], quad_ch0_lo[23:20]};

    // adaptive switching follows the amplitude decision
    assign high_sel = ADAPTIVE_RANGE_SWITCH_ON ? AMPLITUDE_WANTS_HIGH
                                               : MANUAL_HIGH_CURRENT;

    // coefficient for the active channel and current; unheld sets are zero
    logic [11:0] coef_sel;
    assign coef_sel = (EMITTER_CHANNEL == 2'h1) ? (high_sel ? coef_ch1_high : coef_ch1_low) :
                      (EMITTER_CHANNEL == 2'h0) ? (high_sel ? coef_ch0_high : 12'h000) :
                      12'h000;

    ////////////////////////////////////////////////////////////////////////////
    // programmed crosstalk values

    logic signed [23:0] opt_prog_i;
    logic signed [23:0] opt_prog_q;
    logic signed [23:0] elec_prog_i;
    logic signed [23:0] elec_prog_q;
    logic               opt_set_held;

    // only channel zero low current is held in this bank
    assign opt_set_held = (EMITTER_CHANNEL == 2'h0) && !high_sel;
    assign opt_prog_i = opt_set_held ?
        scale_up(inph_ch0_lo[15:0], ctrl.optical_leak_scale_exp) : 24'sh000000;
    assign opt_prog_q = opt_set_held ?
        scale_up(quad_ch0_lo[15:0], ctrl.optical_leak_scale_exp) : 24'sh000000;
    // electrical programmed value lives in a neighbouring bank, zero here
    assign elec_prog_i = scale_up(16'h0000, ctrl.electrical_leak_scale_exp);
    assign elec_prog_q = scale_up(16'h0000, ctrl.electrical_leak_scale_exp);

    ////////////////////////////////////////////////////////////////////////////
    // calibration filters

    logic signed [39:0] elec_acc_i;
    logic signed [39:0] elec_acc_q;
    logic signed [39:0] opt_acc_i;
    logic signed [39:0] opt_acc_q;
    logic signed [23:0] raw_i_ext;
    logic signed [23:0] raw_q_ext;
    logic signed [23:0] elec_cal_i;
    logic signed [23:0] elec_cal_q;
    logic signed [23:0] opt_cal_i;
    logic signed [23:0] opt_cal_q;
    logic signed [23:0] elec_sel_i;
    logic signed [23:0] elec_sel_q;
    logic signed [23:0] opt_sel_i;
    logic signed [23:0] opt_sel_q;
    logic               cal_active;

    assign raw_i_ext  = {{8{RAW_I[15]}}, RAW_I};
    assign raw_q_ext  = {{8{RAW_Q[15]}}, RAW_Q};
    assign elec_cal_i = elec_acc_i[39:FILT_FRAC];
    assign elec_cal_q = elec_acc_q[39:FILT_FRAC];
    assign opt_cal_i  = opt_acc_i[39:FILT_FRAC];
    assign opt_cal_q  = opt_acc_q[39:FILT_FRAC];
    assign cal_active = ctrl.optical_leak_cal_trigger | ctrl.electrical_leak_cal_trigger;

    // source selection between calibrated and programmed values
    assign elec_sel_i = ctrl.electrical_leak_use_programmed ? elec_prog_i : elec_cal_i;
    assign elec_sel_q = ctrl.electrical_leak_use_programmed ? elec_prog_q : elec_cal_q;
    assign opt_sel_i  = ctrl.optical_leak_use_programmed ? opt_prog_i : opt_cal_i;
    assign opt_sel_q  = ctrl.optical_leak_use_programmed ? opt_prog_q : opt_cal_q;

    // electrical leak measured on raw samples while its trigger is set
    always_ff @(posedge MCLK) begin
        if (CE && SRST) begin
            elec_acc_i <= 40'sh0;
            elec_acc_q <= 40'sh0;
        end else if (CE && FRAME_DONE && ctrl.electrical_leak_cal_trigger) begin
            elec_acc_i <= filt_step(elec_acc_i, raw_i_ext, ctrl.leak_filter_tau_exp,
                                    ctrl.electrical_leak_use_filter);
            elec_acc_q <= filt_step(elec_acc_q, raw_q_ext, ctrl.leak_filter_tau_exp,
                                    ctrl.electrical_leak_use_filter);
        end
    end

    // optical leak measured after electrical removal while its trigger is set
    always_ff @(posedge MCLK) begin
        if (CE && SRST) begin
            opt_acc_i <= 40'sh0;
            opt_acc_q <= 40'sh0;
        end else if (CE && FRAME_DONE && ctrl.optical_leak_cal_trigger) begin
            opt_acc_i <= filt_step(opt_acc_i, raw_i_ext - elec_sel_i,
                                   ctrl.leak_filter_tau_exp,
                                   ctrl.optical_leak_use_filter);
            opt_acc_q <= filt_step(opt_acc_q, raw_q_ext - elec_sel_q,
                                   ctrl.leak_filter_tau_exp,
                                   ctrl.optical_leak_use_filter);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // correction, scaling and readback

    logic signed [3:0] forced_exp;
    logic signed [3:0] next_scale_exp;
    logic [15:0]       frame_count;
    logic [23:0]       next_rb_i;
    logic [23:0]       next_rb_q;
    xtcc_iq_s          next_corr;

    assign forced_exp = FORCED_SCALE_BASE - {1'b0, ctrl.manual_gain_scale};
    assign next_scale_exp = (ctrl.auto_gain_scale_off || cal_active) ?
                            forced_exp : AUTO_SCALE_EXP;
    assign next_corr.i = raw_i_ext - elec_sel_i - opt_sel_i;
    assign next_corr.q = raw_q_ext - elec_sel_q - opt_sel_q;

    // readback source for each half of the pair
    assign next_rb_i = route_readback(ctrl.readback_source_select, elec_sel_i, opt_sel_i,
                                      raw_i_ext, frame_count);
    assign next_rb_q = route_readback(ctrl.readback_source_select, elec_sel_q, opt_sel_q,
                                      raw_q_ext, frame_count);

    // frame counter
    always_ff @(posedge MCLK) begin
        if (CE && SRST) begin
            frame_count <= 16'h0000;
        end else if (CE && FRAME_DONE) begin
            frame_count <= frame_count + 16'h0001;
        end
    end

    // per-frame corrected sample
    always_ff @(posedge MCLK) begin
        if (CE && SRST) begin
            CORRECTED_IQ <= '0;
        end else if (CE && FRAME_DONE) begin
            CORRECTED_IQ <= next_corr;
        end
    end

    // emitter current and its phase coefficient
    always_ff @(posedge MCLK) begin
        if (CE && SRST) begin
            EMITTER_HIGH_CURRENT <= 1'b0;
            THERMAL_PHASE_COEF   <= 12'h000;
        end else if (CE) begin
            EMITTER_HIGH_CURRENT <= high_sel;
            THERMAL_PHASE_COEF   <= coef_sel;
        end
    end

    // digital scale exponent for the signal path
    always_ff @(posedge MCLK) begin
        if (CE && SRST) begin
            DIGITAL_SCALE_EXP <= 4'sh0;
        end else if (CE) begin
            DIGITAL_SCALE_EXP <= next_scale_exp;
        end
    end

    // readback registers follow the selected source
    always_ff @(posedge MCLK) begin
        if (CE && SRST) begin
            LEAK_INPHASE_READBACK <= 24'h000000;
            LEAK_QUAD_READBACK    <= 24'h000000;
        end else if (CE) begin
            LEAK_INPHASE_READBACK <= next_rb_i;
            LEAK_QUAD_READBACK    <= next_rb_q;
        end
    end

endmodule // xtcc_top

/* File: testbench/xtcc_chk.sv */
// assertions on the ports of the crosstalk calibration control block
`timescale 1ns/1ps
module xtcc_chk (
    // clock and control
    input wire logic                MCLK,
    input wire logic                SRST,
    input wire logic                CE,
    // register port
    input wire logic                REG_WR_EN,
    input wire logic                REG_RD_EN,
    input wire logic [7:0]          REG_ADDR,
    input wire logic [23:0]         REG_WDATA,
    input wire logic [23:0]         REG_RDATA,
    input wire logic                REG_HIT,
    // datapath
    input wire logic                FRAME_DONE,
    input wire logic [3:0]          AUTO_SCALE_EXP,
    input wire logic                ADAPTIVE_RANGE_SWITCH_ON,
    input wire logic                AMPLITUDE_WANTS_HIGH,
    input wire logic                MANUAL_HIGH_CURRENT,
    input wire logic                EMITTER_HIGH_CURRENT,
    input wire xtcc_pkg::xtcc_iq_s  CORRECTED_IQ,
    input wire logic signed [3:0]   DIGITAL_SCALE_EXP,
    input wire logic [23:0]         LEAK_INPHASE_READBACK,
    input wire logic [23:0]         LEAK_QUAD_READBACK
);
    import xtcc_pkg::*;
    ////////////////////////////////////////////////////////////////
    // shadow of the control register, built from taken writes
    xtcc_ctrl_s ctl;
    xtcc_ctrl_s next_ctl;
    logic       mapped;
    logic       forced;
    assign mapped = REG_ADDR >= OFS_COEF_PAIR_A && REG_ADDR <= OFS_QUAD_CH0_LO;
    assign forced = ctl.auto_gain_scale_off | ctl.optical_leak_cal_trigger
                  | ctl.electrical_leak_cal_trigger;
    assign next_ctl = SRST ? RST_LEAK_CTRL
                    : (REG_WR_EN && REG_ADDR == OFS_LEAK_CTRL) ? (REG_WDATA & MASK_LEAK_CTRL)
                    : ctl;
    // state only moves while enabled
    always_ff @(posedge MCLK) begin
        if (CE) begin
            ctl <= next_ctl;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);
    a_read_hit_mapped: assert property (CE && REG_RD_EN && mapped |=> REG_HIT)
        else $error("mapped read without hit");
    a_unmapped_zero: assert property (CE && REG_RD_EN && !mapped |=>
        !REG_HIT && REG_RDATA == 24'h000000) else $error("unmapped read not zero");
    a_rdata_holds: assert property (!(CE && REG_RD_EN) |=> $stable(REG_RDATA))
        else $error("read data moved without a read");
    a_ctrl_readback: assert property (CE && REG_RD_EN && REG_ADDR == OFS_LEAK_CTRL |=>
        REG_RDATA == $past(ctl)) else $error("control read mismatch");
    a_quad_field_zero: assert property (CE && REG_RD_EN && REG_ADDR == OFS_QUAD_CH0_LO |=>
        REG_RDATA[19:16] == 4'h0) else $error("reserved quad field not zero");
    a_scale_auto: assert property (CE && !forced |=>
        DIGITAL_SCALE_EXP == $past(AUTO_SCALE_EXP)) else $error("auto scale not used");
    a_scale_forced: assert property (CE && forced |=> DIGITAL_SCALE_EXP ==
        4'(FORCED_SCALE_BASE - {1'b0, $past(ctl.manual_gain_scale)}))
        else $error("forced scale wrong");
    a_readback_invalid: assert property (CE && ctl.readback_source_select > SEL_FRAME_COUNT |=>
        LEAK_INPHASE_READBACK == 24'h000000 && LEAK_QUAD_READBACK == 24'h000000)
        else $error("invalid readback code not zero");
    a_current_select: assert property (CE |=> EMITTER_HIGH_CURRENT ==
        ($past(ADAPTIVE_RANGE_SWITCH_ON) ? $past(AMPLITUDE_WANTS_HIGH) : $past(MANUAL_HIGH_CURRENT)))
        else $error("current selection wrong");
    a_iq_holds: assert property (!(CE && FRAME_DONE) |=> $stable(CORRECTED_IQ))
        else $error("corrected sample moved without frame");
    c_optical_cal: cover property (CE && FRAME_DONE && ctl.optical_leak_cal_trigger);
    c_forced_cal: cover property (CE && ctl.electrical_leak_cal_trigger && !ctl.auto_gain_scale_off);
    c_unmapped: cover property (CE && REG_RD_EN && !mapped);
endmodule // xtcc_chk

bind xtcc_top xtcc_chk xtcc_chk_inst (.MCLK, .SRST, .CE, .REG_WR_EN, .REG_RD_EN, .REG_ADDR,
    .REG_WDATA, .REG_RDATA, .REG_HIT, .FRAME_DONE, .AUTO_SCALE_EXP, .ADAPTIVE_RANGE_SWITCH_ON,
    .AMPLITUDE_WANTS_HIGH, .MANUAL_HIGH_CURRENT, .EMITTER_HIGH_CURRENT, .CORRECTED_IQ,
    .DIGITAL_SCALE_EXP, .LEAK_INPHASE_READBACK, .LEAK_QUAD_READBACK);

/* File: testbench/xtcc_top_bench.sv */
// self-checking bench for the crosstalk calibration control block
`timescale 1ns/1ps
module xtcc_top_bench;
    import xtcc_pkg::*;
    typedef struct packed {logic [7:0] a; logic [23:0] w; logic [23:0] r; logic h;} xtcc_row_s;
    logic mclk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, fd = 1'b0, adp = 1'b0, awh = 1'b0;
    logic mhc = 1'b0, ce = 1'b1, hic, hit;
    logic [1:0] ch = 2'd0;
    logic [3:0] ase = 4'h3;
    logic [7:0] addr = 8'h00;
    logic [23:0] wd = 24'h000000, rdata, lir, lqr;
    logic signed [15:0] ri = 16'sh0000, rq = 16'sh0000;
    logic signed [3:0] dse;
    logic [11:0] coef;
    xtcc_iq_s ciq;
    int fail_count = 0, n_tests = 0;
    xtcc_row_s rows [5] = '{'{OFS_COEF_PAIR_A, 24'habc123, 24'habc123, 1'b1},
        '{OFS_LEAK_CTRL, 24'hffffff, 24'hffdfff, 1'b1}, '{OFS_INPH_CH0_LO, 24'h12ffff, 24'h12ffff, 1'b1},
        '{OFS_QUAD_CH0_LO, 24'hffffff, 24'hf0ffff, 1'b1}, '{8'h31, 24'h555555, 24'h000000, 1'b0}};
    logic [11:0] cexp [3] = '{12'habc, 12'h123, 12'h12f};
    logic [27:0] sc [3] = '{28'hffdffff, 28'h0000106, 28'h0000003};

    // 40 MHz clock
    always #12.5 mclk = ~mclk;

    xtcc_top xtcc_top_inst (.MCLK(mclk), .SRST(srst), .CE(ce), .REG_WR_EN(wr), .REG_RD_EN(rd),
        .REG_ADDR(addr), .REG_WDATA(wd), .REG_RDATA(rdata), .REG_HIT(hit), .FRAME_DONE(fd),
        .RAW_I(ri), .RAW_Q(rq), .EMITTER_CHANNEL(ch), .AUTO_SCALE_EXP(ase),
        .ADAPTIVE_RANGE_SWITCH_ON(adp), .AMPLITUDE_WANTS_HIGH(awh), .MANUAL_HIGH_CURRENT(mhc),
        .EMITTER_HIGH_CURRENT(hic), .THERMAL_PHASE_COEF(coef), .CORRECTED_IQ(ciq),
        .DIGITAL_SCALE_EXP(dse), .LEAK_INPHASE_READBACK(lir), .LEAK_QUAD_READBACK(lqr));

    ////////////////////////////////////////////////////////////////
    // edge wait, then the fixed drive delay
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // one register access, write or read
    task automatic acc(input logic w, input logic [7:0] a, input logic [23:0] d);
        wr = w;
        rd = !w;
        addr = a;
        wd = d;
        tick(1);
        wr = 1'b0;
        rd = 1'b0;
        tick(1);
    endtask
    // one frame with its raw sample
    task automatic frame(input logic signed [15:0] i, input logic signed [15:0] q);
        fd = 1'b1;
        ri = i;
        rq = q;
        tick(1);
        fd = 1'b0;
        tick(1);
    endtask
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        tick(2);
        srst = 1'b0;
        // write then read every row
        foreach (rows[k]) begin
            acc(1'b1, rows[k].a, rows[k].w);
            acc(1'b0, rows[k].a, 24'h000000);
            chk("rdata", rows[k].r, rdata);
            chk("hit", 24'(rows[k].h), 24'(hit));
        end
        $display("register table done");
        // coefficient per channel and current
        for (int k = 0; k < 3; k++) begin
            ch = (k == 1) ? 2'd0 : 2'd1;
            mhc = (k != 0);
            tick(3);
            chk("coef", 24'(cexp[k]), 24'(coef));
            chk("current", 24'(mhc), 24'(hic));
        end
        adp = 1'b1;
        awh = 1'b1;
        mhc = 1'b0;
        ch = 2'd0;
        tick(3);
        chk("coef", 24'h000123, 24'(coef));
        chk("current", 24'h000001, 24'(hic));
        $display("coefficient test done");
        // forced, calibration-forced and automatic scaling
        foreach (sc[k]) begin
            acc(1'b1, OFS_LEAK_CTRL, sc[k][27:4]);
            tick(2);
            chk("scale", 24'(sc[k][3:0]), 24'(dse[3:0]));
        end
        $display("scaling test done");
        // second reset, then reset values
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        chk("rdata", 24'h000000, rdata);
        acc(1'b0, OFS_LEAK_CTRL, 24'h000000);
        chk("ctrl", RST_LEAK_CTRL, rdata);
        acc(1'b0, OFS_INPH_CH0_LO, 24'h000000);
        chk("inphase", 24'h000000, rdata);
        acc(1'b0, OFS_QUAD_CH0_LO, 24'h000000);
        chk("quad", 24'h000000, rdata);
        $display("reset test done");
        // writes are lost while the enable is low
        ce = 1'b0;
        acc(1'b1, OFS_INPH_CH0_LO, 24'h00abcd);
        ce = 1'b1;
        acc(1'b0, OFS_INPH_CH0_LO, 24'h000000);
        chk("frozen", 24'h000000, rdata);
        // electrical calibration by direct sampling, tau of one frame
        acc(1'b1, OFS_LEAK_CTRL, 24'h000010);
        repeat (5) frame(16'sd30, -16'sd20);
        acc(1'b1, OFS_LEAK_CTRL, 24'h000000);
        chk("elec i", 24'd30, lir);
        chk("elec q", 24'hffffec, lqr);
        // optical calibration through the filter, tau of two frames
        acc(1'b1, OFS_LEAK_CTRL, 24'h101280);
        repeat (10) frame(16'sd130, -16'sd60);
        acc(1'b1, OFS_LEAK_CTRL, 24'h100280);
        chk("leak i", 24'd99, lir);
        chk("leak q", 24'hffffd8, lqr);
        // programmed leak scaled and subtracted, channel zero low current
        adp = 1'b0;
        acc(1'b1, OFS_INPH_CH0_LO, 24'h000010);
        acc(1'b1, OFS_QUAD_CH0_LO, 24'h000008);
        acc(1'b1, OFS_LEAK_CTRL, 24'h0407e0);
        frame(16'sd1000, -16'sd100);
        chk("corr i", 24'd936, ciq.i);
        chk("corr q", 24'hffff7c, ciq.q);
        chk("frames", 24'h000010, lir);
        acc(1'b1, OFS_LEAK_CTRL, 24'h000400);
        chk("raw i", 24'd1000, lir);
        chk("raw q", 24'hffff9c, lqr);
        $display("datapath test done");
        finish_test();
    end
endmodule // xtcc_top_bench
